//--- tb.sv
// Self-checking bench for the texture block decoder
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
    logic clk, reset_n, in_valid, in_ready, in_extended, in_srgb, out_valid, out_ready;
    logic out_alt_path;
    logic [63:0] in_block;
    logic [383:0] out_texels;
    tbd_pkg::tbd_mode_t out_mode;
    logic [3:0] stall;
    int err_count, checks, cyc;

    tbd_decoder i_tbd_decoder (.clk(clk), .reset_n(reset_n), .in_valid(in_valid),
        .in_ready(in_ready), .in_block(in_block), .in_extended(in_extended),
        .in_srgb(in_srgb), .out_valid(out_valid), .out_ready(out_ready),
        .out_texels(out_texels), .out_mode(out_mode), .out_alt_path(out_alt_path));
    tbd_sink i_tbd_sink (.clk(clk), .reset_n(reset_n), .stall(stall), .out_valid(out_valid),
        .out_texels(out_texels), .out_mode(out_mode), .out_alt_path(out_alt_path),
        .out_ready(out_ready));

    // Clock and a negedge cycle counter, safe to read at rising edges
    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    always @(negedge clk) cyc++;

    task automatic give_verdict();
        if (err_count == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Expected texel; overflowed differential sums wrap as the design chose
    function automatic logic [23:0] ref_texel(input logic [63:0] b, input int t);
        int r, c, sub, p, v, m;
        logic [2:0] sel;
        logic [1:0] idx;
        logic [23:0] res;
        r = t / 4;
        c = t % 4;
        sub = b[24] ? int'(r >= 2) : int'(c >= 2);
        sel = sub ? b[28:26] : b[31:29];
        p = (c < 2) ? 40 + 4 * c + r : 32 + 4 * (c - 2) + r;
        idx = {b[p], b[p + 16]};
        m = idx[0] ? int'(tbd_pkg::LUM_LARGE[sel]) : int'(tbd_pkg::LUM_SMALL[sel]);
        for (int ch = 0; ch < 3; ch++) begin
            if (b[25]) begin
                v = int'(b[8 * ch + 3 +: 5]) + (sub ? int'($signed(b[8 * ch +: 3])) : 0);
                v = {v[4:0], v[4:2]};
            end else begin
                v = sub ? int'(b[8 * ch +: 4]) : int'(b[8 * ch + 4 +: 4]);
                v = {v[3:0], v[3:0]};
            end
            v = idx[1] ? v - m : v + m;
            res[8 * ch +: 8] = (v < 0) ? 8'h00 : (v > 255) ? 8'hff : v[7:0];
        end
        return res;
    endfunction

    function automatic tbd_pkg::tbd_mode_t ref_mode(input logic [63:0] b, input logic e);
        int rs, gs, bs;
        rs = int'(b[7:3]) + int'($signed(b[2:0]));
        gs = int'(b[15:11]) + int'($signed(b[10:8]));
        bs = int'(b[15:11]) + int'($signed(b[18:16]));
        if (!b[25]) return tbd_pkg::MODE_INDIVIDUAL;
        if (!e) return tbd_pkg::MODE_DIFFERENTIAL;
        if (rs < 0 || rs > 31) return tbd_pkg::MODE_T;
        if (gs < 0 || gs > 31) return tbd_pkg::MODE_H;
        if (bs < 0 || bs > 31) return tbd_pkg::MODE_PLANAR;
        return tbd_pkg::MODE_DIFFERENTIAL;
    endfunction

    // Called at a rising edge; returns at the edge that takes the block
    task automatic offer(input logic [63:0] b, input logic e, input logic s);
        in_block <= b;
        in_extended <= e;
        in_srgb <= s;
        in_valid <= 1'h1;
        for (int n = 0; n <= 20; n++) begin
            @(negedge clk);
            if (in_ready === 1'h1) break;
            if (n == 20) begin
                err_count++;
                give_verdict();
            end
        end
        @(posedge clk);
    endtask

    task automatic check_next(input logic [63:0] b, input logic e);
        tbd_pkg::tbd_mode_t m;
        logic [383:0] got;
        logic [3:0] gm;
        m = ref_mode(b, e);
        for (int n = 0; i_tbd_sink.q_tex.size() == 0; n++) begin
            if (n == 20) begin
                err_count++;
                give_verdict();
            end
            @(negedge clk);
        end
        got = i_tbd_sink.q_tex.pop_front();
        gm = i_tbd_sink.q_mode.pop_front();
        `CHK(gm, {m inside {tbd_pkg::MODE_T, tbd_pkg::MODE_H, tbd_pkg::MODE_PLANAR}, m})
        if (!gm[3]) begin
            for (int t = 0; t < 16; t++) `CHK(got[24 * t +: 24], ref_texel(b, t))
        end
        @(posedge clk);
    endtask

    task automatic blk_case(input logic [63:0] b, input logic e, input logic s);
        offer(b, e, s);
        in_valid <= 1'h0;
        check_next(b, e);
    endtask

    task automatic t_individual();
        blk_case(64'h96c35a0f541ed2c7, 1'h0, 1'h0);
        blk_case(64'h00000000000000f0, 1'h0, 1'h0);
    endtask

    // Largest column with red and blue deltas negative; both clamp directions hit
    task automatic t_differential();
        blk_case(64'h3cf0a5e1ff850bfc, 1'h0, 1'h0);
    endtask

    task automatic t_lum_columns();
        for (int k = 0; k < 8; k++) begin
            blk_case({32'h33cc5aa5 + 32'(k) * 32'h13579bdf, 3'(k), ~3'(k), 2'(k), 24'h6b4a29},
                1'h0, 1'h0);
        end
    endtask

    // Planar entry has blue base in range, so only the printed blue test flags it
    task automatic t_modes();
        logic [23:0] col [6] = '{24'h000007, 24'h00f908, 24'h01f808, 24'h000808,
                                 24'h000007, 24'h000007};
        for (int i = 0; i < 6; i++) begin
            blk_case({32'ha55a0ff0, (i == 4) ? 8'h00 : 8'h02, col[i]}, i != 5, 1'h0);
        end
    endtask

    // Only full black and full white, which the curve approximation keeps exact
    task automatic t_srgb();
        blk_case(64'h0000ff00000f0f0f, 1'h1, 1'h1);
    endtask

    task automatic t_stall();
        logic [383:0] held;
        stall <= 4'h3;
        @(posedge clk);
        offer(64'h7e81c33c40a1b2c3, 1'h0, 1'h0);
        in_valid <= 1'h0;
        @(negedge clk);
        held = out_texels;
        @(negedge clk);
        `CHK(in_ready, 1'h0)
        `CHK(out_texels, held)
        @(posedge clk);
        check_next(64'h7e81c33c40a1b2c3, 1'h0);
        stall <= 4'h0;
    endtask

    task automatic t_b2b();
        logic [63:0] b [4];
        int c0;
        c0 = cyc;
        for (int k = 0; k < 4; k++) begin
            b[k] = 64'h0f1e2d3c4b5a6978 + 64'(k) * 64'h1111111111111111;
            offer(b[k], 1'h0, 1'h0);
        end
        in_valid <= 1'h0;
        `CHK(cyc - c0, 4)
        for (int k = 0; k < 4; k++) check_next(b[k], 1'h0);
    endtask

    // Reset, then every scenario in turn
    initial begin
        reset_n = 1'h0;
        in_valid = 1'h0;
        in_block = 64'h0;
        in_extended = 1'h0;
        in_srgb = 1'h0;
        stall = 4'h0;
        repeat (15) @(posedge clk);
        @(negedge clk);
        `CHK({out_valid, in_ready, out_alt_path}, 3'h2)
        @(posedge clk);
        reset_n <= 1'h1;
        @(posedge clk);
        t_individual();
        t_differential();
        t_lum_columns();
        t_modes();
        t_srgb();
        t_stall();
        t_b2b();
        give_verdict();
    end
endmodule

//--- tbd_blk_if.sv
// Decoded block fields shared by all texel lanes
`timescale 1ns/1ps
interface tbd_blk_if;
    logic [63:0] blk;
    logic [23:0] base0;
    logic [23:0] base1;
    logic [2:0] sel0;
    logic [2:0] sel1;
    logic flip;
    logic srgb;

    modport src (output blk, output base0, output base1, output sel0, output sel1,
                 output flip, output srgb);
    modport dst (input blk, input base0, input base1, input sel0, input sel1,
                 input flip, input srgb);
endinterface

//--- tbd_decoder.sv
// Compressed 4x4 texture block decoder with mode detection
`timescale 1ns/1ps
module tbd_decoder #(
    parameter bit BLUE_TEST_USES_GREEN = 1'b1
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [63:0] in_block,
    input wire logic in_extended,
    input wire logic in_srgb,
    output logic out_valid,
    input wire logic out_ready,
    output logic [383:0] out_texels,
    output tbd_pkg::tbd_mode_t out_mode,
    output logic out_alt_path
);
    tbd_blk_if blk_bus ();

    logic accept;
    logic diff;
    logic [4:0] red5;
    logic [4:0] green5;
    logic [4:0] blue5;
    logic [2:0] red_delta;
    logic [2:0] green_delta;
    logic [2:0] blue_delta;
    logic [4:0] red_sum;
    logic [4:0] green_sum;
    logic [4:0] blue_sum;
    logic red_range_test;
    logic green_range_test;
    logic blue_range_test;
    logic [23:0] ind_base0;
    logic [23:0] ind_base1;
    logic [23:0] dif_base0;
    logic [23:0] dif_base1;
    tbd_pkg::tbd_mode_t next_mode;
    logic [23:0] next_texel [16];
    logic [383:0] next_texels;

    // 4-bit and 5-bit channel widening by repeating the top bits
    function automatic logic [7:0] ext4(input logic [3:0] x);
        ext4 = {x, x};
    endfunction

    function automatic logic [7:0] ext5(input logic [4:0] x);
        ext5 = {x, x[4:2]};
    endfunction

    // Base plus sign-extended delta; wraps when out of range
    function automatic logic [4:0] add_delta(input logic [4:0] b, input logic [2:0] d);
        add_delta = 5'(b + {{2{d[2]}}, d});
    endfunction

    // Sum in range exactly when the 6-bit result has a clear top bit
    function automatic logic in_range(input logic [4:0] b, input logic [2:0] d);
        logic [5:0] s;
        s = 6'({1'b0, b} + {{3{d[2]}}, d});
        in_range = ~s[5];
    endfunction

    // One output stage; a stalled filter holds the decoder off
    assign in_ready = ~out_valid | out_ready;
    assign accept = in_valid & in_ready;

    // Field extraction shared by both formats
    assign diff = in_block[tbd_pkg::DIFF_BIT];
    assign red5 = in_block[tbd_pkg::DIF_R_LSB +: 5];
    assign green5 = in_block[tbd_pkg::DIF_G_LSB +: 5];
    assign blue5 = in_block[tbd_pkg::DIF_B_LSB +: 5];
    assign red_delta = in_block[tbd_pkg::DIF_DR_LSB +: 3];
    assign green_delta = in_block[tbd_pkg::DIF_DG_LSB +: 3];
    assign blue_delta = in_block[tbd_pkg::DIF_DB_LSB +: 3];

    // Individual bases, first set for sub-block 0, second for sub-block 1
    assign ind_base0 = {ext4(in_block[tbd_pkg::IND_B0_LSB +: 4]),
                        ext4(in_block[tbd_pkg::IND_G0_LSB +: 4]),
                        ext4(in_block[tbd_pkg::IND_R0_LSB +: 4])};
    assign ind_base1 = {ext4(in_block[tbd_pkg::IND_B1_LSB +: 4]),
                        ext4(in_block[tbd_pkg::IND_G1_LSB +: 4]),
                        ext4(in_block[tbd_pkg::IND_R1_LSB +: 4])};

    // Differential bases; out-of-range sums are undefined and simply wrap
    assign red_sum = add_delta(red5, red_delta);
    assign green_sum = add_delta(green5, green_delta);
    assign blue_sum = add_delta(blue5, blue_delta);
    assign dif_base0 = {ext5(blue5), ext5(green5), ext5(red5)};
    assign dif_base1 = {ext5(blue_sum), ext5(green_sum), ext5(red_sum)};

    // Range tests; the blue test base source is a build-time choice
    assign red_range_test = in_range(red5, red_delta);
    assign green_range_test = in_range(green5, green_delta);
    assign blue_range_test = in_range(BLUE_TEST_USES_GREEN ? green5 : blue5, blue_delta);

    // Mode choice; the base format never leaves the two classic modes
    always_comb begin
        if (!diff) begin
            next_mode = tbd_pkg::MODE_INDIVIDUAL;
        end else if (!in_extended) begin
            next_mode = tbd_pkg::MODE_DIFFERENTIAL;
        end else if (!red_range_test) begin
            next_mode = tbd_pkg::MODE_T;
        end else if (!green_range_test) begin
            next_mode = tbd_pkg::MODE_H;
        end else if (!blue_range_test) begin
            next_mode = tbd_pkg::MODE_PLANAR;
        end else begin
            next_mode = tbd_pkg::MODE_DIFFERENTIAL;
        end
    end

    // Fields handed to the sixteen texel lanes
    assign blk_bus.blk = in_block;
    assign blk_bus.base0 = diff ? dif_base0 : ind_base0;
    assign blk_bus.base1 = diff ? dif_base1 : ind_base1;
    assign blk_bus.sel0 = in_block[tbd_pkg::SEL0_LSB +: 3];
    assign blk_bus.sel1 = in_block[tbd_pkg::SEL1_LSB +: 3];
    assign blk_bus.flip = in_block[tbd_pkg::FLIP_BIT];
    assign blk_bus.srgb = in_srgb & in_extended;

    // Texel t = row * 4 + column, red in the low byte
    for (genvar t = 0; t < tbd_pkg::TEXELS; t++) begin : g_texel
        tbd_texel #(
            .ROW(t / tbd_pkg::COLS),
            .COL(t % tbd_pkg::COLS)
        ) u_texel (
            .bus(blk_bus.dst),
            .texel(next_texel[t])
        );
        assign next_texels[tbd_pkg::TEXEL_W * t +: tbd_pkg::TEXEL_W] = next_texel[t];
    end

    // Output valid: set on accept, cleared when the filter takes it
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_valid <= 1'b0;
        end else if (accept) begin
            out_valid <= 1'b1;
        end else if (out_ready) begin
            out_valid <= 1'b0;
        end
    end

    // Output data, loaded only on accept so a stall holds it steady
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_texels <= '0;
            out_mode <= tbd_pkg::MODE_INDIVIDUAL;
            out_alt_path <= 1'b0;
        end else if (accept) begin
            out_texels <= next_texels;
            out_mode <= next_mode;
            out_alt_path <= (next_mode == tbd_pkg::MODE_T) || (next_mode == tbd_pkg::MODE_H)
                            || (next_mode == tbd_pkg::MODE_PLANAR);
        end
    end

    a_accept_valid: assert property (@(posedge clk) disable iff (!reset_n)
        accept |=> out_valid && (out_texels == $past(next_texels)))
        else $error("Accepted block not presented next cycle");

    a_stall_hold: assert property (@(posedge clk) disable iff (!reset_n)
        out_valid && !out_ready |-> !in_ready ##1 (out_valid && $stable(out_texels)))
        else $error("Output changed while stalled");

    a_ind_base: assert property (@(posedge clk) disable iff (!reset_n)
        accept && !diff |-> blk_bus.base1[7:0] == {in_block[3:0], in_block[3:0]}
                         && blk_bus.base0[23:16] == {in_block[23:20], in_block[23:20]})
        else $error("Individual base colour wrong");

    a_diff_base: assert property (@(posedge clk) disable iff (!reset_n)
        accept && diff |-> blk_bus.base1[15:8] ==
            {5'(in_block[15:11] + {{2{in_block[10]}}, in_block[10:8]}),
             3'(5'(in_block[15:11] + {{2{in_block[10]}}, in_block[10:8]}) >> 2)})
        else $error("Differential base colour wrong");

    a_lum_first: assert property (@(posedge clk) disable iff (!reset_n)
        accept && !in_srgb && !diff && in_block[63:26] == 38'h0 |=>
            out_texels[7:0] == (($past(in_block[7:4]) == 4'hf) ? 8'hff
                               : 8'({$past(in_block[7:4]), $past(in_block[7:4])} + 8'h02)))
        else $error("Texel 0 luminance sum wrong");

    a_mode_ind: assert property (@(posedge clk) disable iff (!reset_n)
        accept && !diff |=> out_mode == tbd_pkg::MODE_INDIVIDUAL && !out_alt_path)
        else $error("Individual mode not reported");

    a_mode_t: assert property (@(posedge clk) disable iff (!reset_n)
        accept && diff && in_extended && in_block[7:3] == 5'h00 && in_block[2] |=>
            out_mode == tbd_pkg::MODE_T)
        else $error("Red underflow not reported as T mode");

    a_base_no_alt: assert property (@(posedge clk) disable iff (!reset_n)
        accept && !in_extended |=> !out_alt_path)
        else $error("Base format flagged an extended mode");

    a_alt_flag: assert property (@(posedge clk) disable iff (!reset_n)
        out_valid |-> out_alt_path == (out_mode inside {tbd_pkg::MODE_T, tbd_pkg::MODE_H,
                                                        tbd_pkg::MODE_PLANAR}))
        else $error("Alternate path flag disagrees with mode");
endmodule

//--- tbd_pkg.sv
// Shared constants, field positions and types for the texture block decoder
package tbd_pkg;
    // Geometry of one compressed block
    localparam int BLK_W = 64;
    localparam int ROWS = 4;
    localparam int COLS = 4;
    localparam int TEXELS = 16;
    localparam int CH_W = 8;
    localparam int TEXEL_W = 24;

    // Individual mode colour fields, low bit of each nibble
    localparam int IND_R0_LSB = 4;
    localparam int IND_R1_LSB = 0;
    localparam int IND_G0_LSB = 12;
    localparam int IND_G1_LSB = 8;
    localparam int IND_B0_LSB = 20;
    localparam int IND_B1_LSB = 16;

    // Differential mode fields: 5-bit bases and 3-bit deltas
    localparam int DIF_R_LSB = 3;
    localparam int DIF_DR_LSB = 0;
    localparam int DIF_G_LSB = 11;
    localparam int DIF_DG_LSB = 8;
    localparam int DIF_B_LSB = 19;
    localparam int DIF_DB_LSB = 16;

    // Control fields
    localparam int SEL0_LSB = 29;
    localparam int SEL1_LSB = 26;
    localparam int DIFF_BIT = 25;
    localparam int FLIP_BIT = 24;

    // Per-texel index bit placement
    localparam int IDX_MSB_LEFT = 40;
    localparam int IDX_MSB_RIGHT = 32;
    localparam int IDX_LSB_OFS = 16;

    // Luminance magnitudes, rows 0 and 1; rows 2 and 3 are their negatives
    localparam logic [7:0] LUM_SMALL [8] = '{8'h02, 8'h05, 8'h09, 8'h0d,
                                             8'h12, 8'h18, 8'h21, 8'h2f};
    localparam logic [7:0] LUM_LARGE [8] = '{8'h08, 8'h11, 8'h1d, 8'h2a,
                                             8'h3c, 8'h50, 8'h6a, 8'hb7};

    // Linear to sRGB curve sampled every 16 codes, last knot at full scale
    localparam logic [7:0] SRGB_KNOT [17] = '{8'h00, 8'h47, 8'h63, 8'h78, 8'h89,
                                              8'h98, 8'ha5, 8'hb1, 8'hbc, 8'hc6,
                                              8'hd0, 8'hd9, 8'he1, 8'he9, 8'hf1,
                                              8'hf8, 8'hff};

    // Block mode reported with each decoded block
    typedef enum logic [2:0] {
        MODE_INDIVIDUAL,
        MODE_DIFFERENTIAL,
        MODE_T,
        MODE_H,
        MODE_PLANAR
    } tbd_mode_t;
endpackage

//--- tbd_sink.sv
// Filter-side model that takes decoded blocks and can stall
`timescale 1ns/1ps
module tbd_sink (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] stall,
    input wire logic out_valid,
    input wire logic [383:0] out_texels,
    input wire logic [2:0] out_mode,
    input wire logic out_alt_path,
    output logic out_ready
);
    logic [3:0] cnt;
    logic [383:0] q_tex [$];
    logic [3:0] q_mode [$];

    // Ready stays low for stall cycles of each block, so the hold phase is exercised
    always @(posedge clk) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            out_ready <= 1'h1;
        end else if (out_valid && out_ready) begin
            q_tex.push_back(out_texels);
            q_mode.push_back({out_alt_path, out_mode});
            cnt <= 4'h0;
            out_ready <= (stall == 4'h0);
        end else begin
            cnt <= cnt + 4'(out_valid);
            out_ready <= (stall == 4'h0) || (out_valid && (cnt + 4'h1 >= stall));
        end
    end
endmodule

//--- tbd_texel.sv
// One texel lane: sub-block choice, luminance modulation, clamp and sRGB
`timescale 1ns/1ps
module tbd_texel #(
    parameter int ROW = 0,
    parameter int COL = 0
) (
    tbd_blk_if.dst bus,
    output logic [23:0] texel
);
    // Where this texel's two index bits live
    localparam int MSB_POS = (COL < 2) ? tbd_pkg::IDX_MSB_LEFT + 4 * COL + ROW
                                       : tbd_pkg::IDX_MSB_RIGHT + 4 * (COL - 2) + ROW;
    localparam int LSB_POS = MSB_POS + tbd_pkg::IDX_LSB_OFS;
    localparam bit IN_RIGHT = (COL >= 2);
    localparam bit IN_BOTTOM = (ROW >= 2);

    logic sub_sel;
    logic [23:0] base;
    logic [2:0] col_sel;
    logic [1:0] row_sel;
    logic [7:0] mag;

    // Base plus signed offset, saturated to the 8-bit range
    function automatic logic [7:0] add_clamp(input logic [7:0] b, input logic [7:0] m,
                                             input logic neg);
        logic [8:0] s;
        s = {1'b0, b} + {1'b0, m};
        if (neg) begin
            add_clamp = (m > b) ? 8'h00 : 8'(b - m);
        end else begin
            add_clamp = s[8] ? 8'hff : s[7:0];
        end
    endfunction

    // Piecewise-linear curve; error is largest near black, where the first segment is steepest.
    // The step is rounded, not truncated, so full white lands on the top knot.
    function automatic logic [7:0] to_srgb(input logic [7:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        logic [11:0] prod;
        lo = tbd_pkg::SRGB_KNOT[v[7:4]];
        hi = tbd_pkg::SRGB_KNOT[5'({1'b0, v[7:4]} + 5'h01)];
        prod = 12'(8'(hi - lo) * v[3:0]) + 12'h008;
        to_srgb = 8'(lo + prod[11:4]);
    endfunction

    // Sub-block split follows the orientation bit
    assign sub_sel = bus.flip ? IN_BOTTOM : IN_RIGHT;
    assign base = sub_sel ? bus.base1 : bus.base0;
    assign col_sel = sub_sel ? bus.sel1 : bus.sel0;
    assign row_sel = {bus.blk[MSB_POS], bus.blk[LSB_POS]};
    // Odd rows take the large magnitudes, the upper two rows are negative
    assign mag = row_sel[0] ? tbd_pkg::LUM_LARGE[col_sel] : tbd_pkg::LUM_SMALL[col_sel];

    // Same offset on every channel, then optional sRGB encode
    for (genvar ch = 0; ch < 3; ch++) begin : g_ch
        logic [7:0] lin;
        assign lin = add_clamp(base[8 * ch +: 8], mag, row_sel[1]);
        assign texel[8 * ch +: 8] = bus.srgb ? to_srgb(lin) : lin;
    end
endmodule
